// File: verilog/dio_pkg.sv
package dio_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RATE_MAX_HZ = 2000;
  localparam int unsigned RATE_MIN_MHZ = 500;  // 0.5 Hz in millihertz
  localparam int unsigned RATE_RST_HZ = 10;
  localparam int unsigned DIV_MIN = CLK_HZ / RATE_MAX_HZ;
  localparam int unsigned DIV_MAX =
    32'(longint'(CLK_HZ) * 64'd1000 / longint'(RATE_MIN_MHZ));
  localparam int unsigned DIV_RST = CLK_HZ / RATE_RST_HZ;
  localparam int unsigned TS_UNIT_US = 1000;  // timestamp and pulse unit
  localparam int unsigned TS_CYCLES = CLK_HZ / 1_000_000 * TS_UNIT_US;

  // ------------------------------------------------------------
  // line layout
  // ------------------------------------------------------------
  localparam int unsigned N_LINES = 8;
  localparam int unsigned N_ENC = 4;
  localparam logic [7:0] OUT_MASK = 8'h7e;   // lines 2..7
  localparam logic [7:0] THR_RST = 8'h01;
  localparam logic [7:0] ALM_RST = 8'h01;
  localparam int unsigned ST_RUN_DONE = 16;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_INVERT = 8'h08;
  localparam logic [7:0] OFS_BOTH = 8'h0c;
  localparam logic [7:0] OFS_FILT_EN = 8'h10;
  localparam logic [7:0] OFS_ENC_EN = 8'h14;
  localparam logic [7:0] OFS_SENS = 8'h18;
  localparam logic [7:0] OFS_OUT = 8'h1c;
  localparam logic [7:0] OFS_PULSE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_LEVELS = 8'h28;
  localparam logic [7:0] OFS_TIME = 8'h2c;
  localparam logic [7:0] OFS_THR = 8'h40;    // 8 words
  localparam logic [7:0] OFS_ALM = 8'h60;    // 8 words
  localparam logic [7:0] OFS_CNT = 8'h80;    // 8 words
  localparam logic [7:0] OFS_TS = 8'ha0;     // 8 words
  localparam logic [7:0] OFS_ECNT = 8'hc0;   // 4 words
  localparam logic [7:0] OFS_ETHR = 8'hd0;   // 4 words
  localparam logic [15:0] ETHR_RST = 16'h0101;

  typedef enum logic [1:0] {
    st_stop = 2'b01,
    st_run = 2'b10
  } dio_run_e;

endpackage

// File: verilog/dio_top.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - eight lines; lines 2..7 can drive outputs, lines 1 and 8 input only
// - filter counts up on a one, down on a zero, each sample tick
// - filter count holds at its threshold and at zero
// - filter output goes low at zero, high at threshold, else holds
// - each line has its own threshold; host writes 1..255 only
// - selected line's filter output drives a 32-bit event counter
// - lines given to an encoder skip the filter
// - count rising or both edges; inversion gives falling edge
// - counter alarm after a programmed 1..255 counts
// - each count stamps the time; time is read beside the count
// - run command loads current levels as each filter's start state
// - sampling starts on run at the programmed 0.5..2000 Hz rate
// - four encoders on pairs starting at an odd line; host assigns
// - encoder 32-bit counter up one way, down the other; invert swaps
// - each encoder holds an up and a down threshold, 1..255
// - when enabled, alarms raise a message to the host
// - outputs set on or off by command, and pulsable by command while running
// - line one is bit zero of every multi-line value
// - lines 7 and 8 have a high sensitivity select
module dio_top #(
  parameter int unsigned TS_CYCLES = dio_pkg::TS_CYCLES,
  parameter int unsigned DIV_RESET = dio_pkg::DIV_RST
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] line_in,
  output logic [7:0] line_out,
  output logic [7:0] line_oe,
  output logic [1:0] sens_hi
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (TS_CYCLES < 1 || DIV_RESET < dio_pkg::DIV_MIN ||
      DIV_RESET > dio_pkg::DIV_MAX) begin : g_bad
    $error("dio_top: parameter out of range");
  end

  localparam int unsigned NL = dio_pkg::N_LINES;
  localparam int unsigned NE = dio_pkg::N_ENC;

  function automatic logic [1:0] enc_step(input logic [1:0] p,
                                          input logic [1:0] c);
    // bit0 = up, bit1 = down, gray order 00-01-11-10 counts up
    case ({p, c})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: enc_step = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: enc_step = 2'b10;
      default: enc_step = 2'b00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] sync1_ff, sync2_ff;
  logic ack_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  dio_pkg::dio_run_e state_ff, nxt_state;
  logic alm_en_ff, nxt_alm_en;
  logic [31:0] rate_ff, nxt_rate, div_ff, nxt_div;
  logic [7:0] inv_ff, nxt_inv, both_ff, nxt_both, fen_ff, nxt_fen;
  logic [3:0] een_ff, nxt_een;
  logic [1:0] sens_ff, nxt_sens;
  logic [7:0] olvl_ff, nxt_olvl, oe_ff, nxt_oe;
  logic [31:0] stat_ff, nxt_stat;
  logic [31:0] tsdiv_ff, nxt_tsdiv, time_ff, nxt_time;
  logic [7:0] samp_ff, nxt_samp, fout_ff, nxt_fout, prev_ff, nxt_prev;
  logic [7:0] thr_ff [NL], nxt_thr [NL];
  logic [7:0] alm_ff [NL], nxt_alm [NL];
  logic [7:0] fcnt_ff [NL], nxt_fcnt [NL];
  logic [7:0] acnt_ff [NL], nxt_acnt [NL];
  logic [31:0] cnt_ff [NL], nxt_cnt [NL];
  logic [31:0] ts_ff [NL], nxt_ts [NL];
  logic [15:0] ptmr_ff [NL], nxt_ptmr [NL];
  logic [31:0] ecnt_ff [NE], nxt_ecnt [NE];
  logic [15:0] ethr_ff [NE], nxt_ethr [NE];
  logic signed [8:0] epos_ff [NE], nxt_epos [NE];

  logic [31:0] rmux, bemask, w32, sset;
  logic wr, running, tick, ms_tick;
  logic [7:0] vv, encline, pact;

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= line_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ------------------------------------------------------------
  // bus read mux
  // ------------------------------------------------------------
  always_comb begin
    rmux = 32'h0;
    unique case (address[7:5])
      3'd2: rmux = {24'h0, thr_ff[address[4:2]]};
      3'd3: rmux = {24'h0, alm_ff[address[4:2]]};
      3'd4: rmux = cnt_ff[address[4:2]];
      3'd5: rmux = ts_ff[address[4:2]];
      3'd6: begin
        if (address[4])
          rmux = {16'h0, ethr_ff[address[3:2]]};
        else
          rmux = ecnt_ff[address[3:2]];
      end
      3'd0, 3'd1: begin
        case ({address[7:2], 2'b00})
          dio_pkg::OFS_CTRL: rmux = {30'h0, alm_en_ff, running};
          dio_pkg::OFS_RATE: rmux = rate_ff;
          dio_pkg::OFS_INVERT: rmux = {24'h0, inv_ff};
          dio_pkg::OFS_BOTH: rmux = {24'h0, both_ff};
          dio_pkg::OFS_FILT_EN: rmux = {24'h0, fen_ff};
          dio_pkg::OFS_ENC_EN: rmux = {28'h0, een_ff};
          dio_pkg::OFS_SENS: rmux = {30'h0, sens_ff};
          dio_pkg::OFS_OUT: rmux = {24'h0, olvl_ff};
          dio_pkg::OFS_PULSE: rmux = {24'h0, pact};
          dio_pkg::OFS_STATUS: rmux = stat_ff;
          dio_pkg::OFS_LEVELS: rmux = {16'h0, fout_ff, sync2_ff};
          dio_pkg::OFS_TIME: rmux = time_ff;
          default: rmux = 32'h0;
        endcase
      end
      default: rmux = 32'h0;
    endcase
  end

  assign bemask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign w32 = (rmux & ~bemask) | (writedata & bemask);
  assign wr = write & ack_ff;
  assign waitrequest = (read | write) & ~ack_ff;
  assign readdata = rdata_ff;
  assign running = state_ff == dio_pkg::st_run;
  assign tick = running && (div_ff == rate_ff - 32'h1);
  assign ms_tick = tsdiv_ff == TS_CYCLES - 1;
  assign line_out = 8'h00;  // open drain: only the enable switches
  assign line_oe = oe_ff;
  assign sens_hi = sens_ff;

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      pact[i] = ptmr_ff[i] != 16'h0;
      encline[i] = een_ff[i / 2];
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic cur, src, nout, edg;
    logic [7:0] c;
    logic [1:0] st;
    logic signed [8:0] p;
    cur = 1'b0;
    src = 1'b0;
    nout = 1'b0;
    edg = 1'b0;
    c = 8'h00;
    st = 2'b00;
    p = 9'sh0;
    vv = 8'h00;
    sset = 32'h0;
    nxt_rdata = rdata_ff;
    nxt_state = state_ff;
    nxt_alm_en = alm_en_ff;
    nxt_rate = rate_ff;
    nxt_inv = inv_ff;
    nxt_both = both_ff;
    nxt_fen = fen_ff;
    nxt_een = een_ff;
    nxt_sens = sens_ff;
    nxt_olvl = olvl_ff;
    nxt_samp = samp_ff;
    nxt_fout = fout_ff;
    nxt_prev = prev_ff;
    nxt_thr = thr_ff;
    nxt_alm = alm_ff;
    nxt_fcnt = fcnt_ff;
    nxt_acnt = acnt_ff;
    nxt_cnt = cnt_ff;
    nxt_ts = ts_ff;
    nxt_ptmr = ptmr_ff;
    nxt_ecnt = ecnt_ff;
    nxt_ethr = ethr_ff;
    nxt_epos = epos_ff;
    nxt_div = tick || !running ? 32'h0 : div_ff + 32'h1;
    nxt_tsdiv = ms_tick ? 32'h0 : tsdiv_ff + 32'h1;
    nxt_time = ms_tick ? time_ff + 32'h1 : time_ff;
    if (read && !ack_ff)
      nxt_rdata = rmux;

    // pulse timers run down in time units, then the level returns
    for (int i = 0; i < NL; i++) begin
      if (ms_tick && pact[i])
        nxt_ptmr[i] = ptmr_ff[i] - 16'h1;
    end

    if (tick) begin
      nxt_samp = sync2_ff;
      for (int i = 0; i < NL; i++) begin
        cur = sync2_ff[i];
        c = fcnt_ff[i];
        if (cur && c < thr_ff[i])
          c = c + 8'h1;
        else if (!cur && c != 8'h00)
          c = c - 8'h1;
        nout = fout_ff[i];
        if (c == 8'h00)
          nout = 1'b0;
        else if (c >= thr_ff[i])
          nout = 1'b1;
        nxt_fcnt[i] = c;
        nxt_fout[i] = nout;
        src = (fen_ff[i] && !encline[i]) ? nout : cur;
        vv[i] = src ^ inv_ff[i];
        edg = both_ff[i] ? (vv[i] != prev_ff[i]) : (vv[i] & ~prev_ff[i]);
        if (edg && !encline[i]) begin
          nxt_cnt[i] = cnt_ff[i] + 32'h1;
          nxt_ts[i] = time_ff;
          if (acnt_ff[i] + 8'h1 >= alm_ff[i]) begin
            nxt_acnt[i] = 8'h00;
            sset[i] = alm_en_ff;
          end else begin
            nxt_acnt[i] = acnt_ff[i] + 8'h1;
          end
        end
      end
      nxt_prev = vv;
      // encoder k takes lines 2k+1 and 2k+2, counted from one
      for (int k = 0; k < NE; k++) begin
        if (een_ff[k]) begin
          st = enc_step({prev_ff[2*k], prev_ff[2*k+1]},
                        {vv[2*k], vv[2*k+1]});
          p = epos_ff[k];
          if (st[0]) begin
            nxt_ecnt[k] = ecnt_ff[k] + 32'h1;
            p = p + 9'sh1;
            if (p >= $signed({1'b0, ethr_ff[k][7:0]})) begin
              p = 9'sh0;
              sset[8 + k] = alm_en_ff;
            end
          end else if (st[1]) begin
            nxt_ecnt[k] = ecnt_ff[k] - 32'h1;
            p = p - 9'sh1;
            if (p <= -$signed({1'b0, ethr_ff[k][15:8]})) begin
              p = 9'sh0;
              sset[12 + k] = alm_en_ff;
            end
          end
          nxt_epos[k] = p;
        end
      end
    end

    // software writes land after the datapath and win over it
    if (wr) begin
      unique case (address[7:5])
        3'd2: nxt_thr[address[4:2]] = w32[7:0];
        3'd3: nxt_alm[address[4:2]] = w32[7:0];
        3'd4: nxt_cnt[address[4:2]] = w32;
        3'd5: nxt_ts[address[4:2]] = w32;
        3'd6: begin
          if (address[4])
            nxt_ethr[address[3:2]] = w32[15:0];
          else
            nxt_ecnt[address[3:2]] = w32;
        end
        3'd0, 3'd1: begin
          case ({address[7:2], 2'b00})
            dio_pkg::OFS_CTRL: begin
              nxt_alm_en = w32[1];
              if (w32[0]) begin
                // run: restart pacing and seed filters from the pins
                nxt_state = dio_pkg::st_run;
                nxt_div = 32'h0;
                nxt_samp = sync2_ff;
                nxt_fout = sync2_ff;
                nxt_prev = sync2_ff ^ inv_ff;
                for (int i = 0; i < NL; i++) begin
                  nxt_fcnt[i] = sync2_ff[i] ? thr_ff[i] : 8'h00;
                  nxt_acnt[i] = 8'h00;
                end
                for (int k = 0; k < NE; k++)
                  nxt_epos[k] = 9'sh0;
                sset[dio_pkg::ST_RUN_DONE] = 1'b1;
              end else begin
                nxt_state = dio_pkg::st_stop;
                for (int i = 0; i < NL; i++)
                  nxt_ptmr[i] = 16'h0;
              end
            end
            dio_pkg::OFS_RATE: begin
              if (w32 < dio_pkg::DIV_MIN)
                nxt_rate = dio_pkg::DIV_MIN;
              else if (w32 > dio_pkg::DIV_MAX)
                nxt_rate = dio_pkg::DIV_MAX;
              else
                nxt_rate = w32;
            end
            dio_pkg::OFS_INVERT: nxt_inv = w32[7:0];
            dio_pkg::OFS_BOTH: nxt_both = w32[7:0];
            dio_pkg::OFS_FILT_EN: nxt_fen = w32[7:0];
            dio_pkg::OFS_ENC_EN: nxt_een = w32[3:0];
            dio_pkg::OFS_SENS: nxt_sens = w32[1:0];
            dio_pkg::OFS_OUT:
              nxt_olvl = w32[7:0] & dio_pkg::OUT_MASK;
            dio_pkg::OFS_PULSE: begin
              // stopped device ignores pulses; input-only lines too
              if (running && dio_pkg::OUT_MASK[writedata[2:0]])
                nxt_ptmr[writedata[2:0]] = writedata[31:16];
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // status: set wins over write-one-to-clear
    nxt_stat = stat_ff;
    if (wr && {address[7:2], 2'b00} == dio_pkg::OFS_STATUS)
      nxt_stat = stat_ff & ~(writedata & bemask);
    nxt_stat = nxt_stat | sset;

    for (int i = 0; i < NL; i++)
      nxt_oe[i] = (nxt_olvl[i] ^ (nxt_ptmr[i] != 16'h0))
                  & dio_pkg::OUT_MASK[i];
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      state_ff <= dio_pkg::st_stop;
      alm_en_ff <= 1'b0;
      rate_ff <= DIV_RESET;
      div_ff <= 32'h0;
      inv_ff <= 8'h00;
      both_ff <= 8'h00;
      fen_ff <= 8'h00;
      een_ff <= 4'h0;
      sens_ff <= 2'b00;
      olvl_ff <= 8'h00;
      oe_ff <= 8'h00;
      stat_ff <= 32'h0;
      tsdiv_ff <= 32'h0;
      time_ff <= 32'h0;
      samp_ff <= 8'h00;
      fout_ff <= 8'h00;
      prev_ff <= 8'h00;
      for (int i = 0; i < NL; i++) begin
        thr_ff[i] <= dio_pkg::THR_RST;
        alm_ff[i] <= dio_pkg::ALM_RST;
        fcnt_ff[i] <= 8'h00;
        acnt_ff[i] <= 8'h00;
        cnt_ff[i] <= 32'h0;
        ts_ff[i] <= 32'h0;
        ptmr_ff[i] <= 16'h0;
      end
      for (int k = 0; k < NE; k++) begin
        ecnt_ff[k] <= 32'h0;
        ethr_ff[k] <= dio_pkg::ETHR_RST;
        epos_ff[k] <= 9'sh0;
      end
    end else begin
      ack_ff <= (read | write) & ~ack_ff;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      alm_en_ff <= nxt_alm_en;
      rate_ff <= nxt_rate;
      div_ff <= nxt_div;
      inv_ff <= nxt_inv;
      both_ff <= nxt_both;
      fen_ff <= nxt_fen;
      een_ff <= nxt_een;
      sens_ff <= nxt_sens;
      olvl_ff <= nxt_olvl;
      oe_ff <= nxt_oe;
      stat_ff <= nxt_stat;
      tsdiv_ff <= nxt_tsdiv;
      time_ff <= nxt_time;
      samp_ff <= nxt_samp;
      fout_ff <= nxt_fout;
      prev_ff <= nxt_prev;
      thr_ff <= nxt_thr;
      alm_ff <= nxt_alm;
      fcnt_ff <= nxt_fcnt;
      acnt_ff <= nxt_acnt;
      cnt_ff <= nxt_cnt;
      ts_ff <= nxt_ts;
      ptmr_ff <= nxt_ptmr;
      ecnt_ff <= nxt_ecnt;
      ethr_ff <= nxt_ethr;
      epos_ff <= nxt_epos;
    end
  end

endmodule

// File: testbench/dio_top_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker for the digital io block
// ------------------------------------------
module dio_top_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [7:0] line_out,
  input wire logic [7:0] line_oe,
  input wire logic [1:0] sens_hi
);
  logic wacc, oacc, pacc, pok;
  logic run_ff, nxt_run;
  logic [7:0] out_ff, nxt_out;
  logic [1:0] sens_ff, nxt_sens;
  logic [2:0] pidx_ff, nxt_pidx;

  // ------------------------------------------
  // shadow of the host commands
  // ------------------------------------------
  always_comb begin
    wacc = write && !waitrequest && byteenable[0];
    oacc = wacc && address[7:2] == 6'h07;
    pacc = wacc && address[7:2] == 6'h08;
    // lines 1 and 8 cannot drive, so their pulses are dropped
    pok = pacc && writedata[2:0] != 3'h0 && writedata[2:0] != 3'h7
      && writedata[31:16] != 16'h0;
    nxt_run = run_ff;
    nxt_out = out_ff;
    nxt_sens = sens_ff;
    nxt_pidx = pidx_ff;
    if (wacc && address[7:2] == 6'h00)
      nxt_run = writedata[0];
    if (oacc)
      nxt_out = writedata[7:0] & dio_pkg::OUT_MASK;
    if (wacc && address[7:2] == 6'h06)
      nxt_sens = writedata[1:0];
    if (pacc)
      nxt_pidx = writedata[2:0];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_ff <= 1'b0;
      out_ff <= 8'h00;
      sens_ff <= 2'h0;
      pidx_ff <= 3'h0;
    end else begin
      run_ff <= nxt_run;
      out_ff <= nxt_out;
      sens_ff <= nxt_sens;
      pidx_ff <= nxt_pidx;
    end
  end

  // ------------------------------------------
  // properties
  // ------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_wait_one; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("request held off more than one cycle");
  property p_oe_mask; line_oe[0] == 1'b0 && line_oe[7] == 1'b0; endproperty
  a_oe_mask: assert property (p_oe_mask)
    else $error("input-only line driven");
  property p_out_zero; line_oe != 8'h00 |-> line_out == 8'h00; endproperty
  a_out_zero: assert property (p_out_zero)
    else $error("open drain line driven high");
  property p_oe_write; oacc && !run_ff |=> ##[0:2] line_oe == out_ff;
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("output write not applied");
  property p_oe_quiet; (!run_ff && !write) [*3] |-> line_oe == out_ff;
  endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("stopped outputs differ from commanded levels");
  property p_sens; (!write) [*3] |-> sens_hi == sens_ff; endproperty
  a_sens: assert property (p_sens)
    else $error("sensitivity select differs from command");
  property p_rd_hold; !read |=> $stable(readdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_pulse_on;
    pok && run_ff |=> ##[0:2] line_oe[pidx_ff] != out_ff[pidx_ff];
  endproperty
  a_pulse_on: assert property (p_pulse_on)
    else $error("pulse did not invert the output");
  property p_pulse_off;
    pacc && !run_ff |=> $stable(line_oe) ##1 $stable(line_oe);
  endproperty
  a_pulse_off: assert property (p_pulse_off)
    else $error("pulse acted while stopped");

  c_pulse: cover property (pok && run_ff);
  c_pulse_stopped: cover property (pacc && !run_ff);
  c_out: cover property (oacc);
endmodule

bind dio_top dio_top_checker u_chk (
  .mclk(mclk),
  .rst(rst),
  .address(address),
  .read(read),
  .write(write),
  .writedata(writedata),
  .byteenable(byteenable),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .line_out(line_out),
  .line_oe(line_oe),
  .sens_hi(sens_hi)
);

// File: testbench/dio_field.sv
`timescale 1ns/1ps
// ------------------------------------------
// field wiring: sensors behind open-drain pins
// ------------------------------------------
module dio_field (
  input wire logic [7:0] sensor,
  input wire logic [7:0] line_out,
  input wire logic [7:0] line_oe,
  output logic [7:0] line_in
);
  // a closed switch wins over the sensor; bit zero is line one
  assign line_in = (line_oe & line_out) | (~line_oe & sensor);
endmodule

// File: testbench/dio_top_tb.sv
`timescale 1ns/1ps
module dio_top_tb;
  logic mclk, rst, read, write, waitrequest;
  logic [7:0] address, sensor, line_in, line_out, line_oe;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [1:0] sens_hi;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int run_cyc = 0;

  dio_top #(.TS_CYCLES(10)) u_dut (.mclk(mclk), .rst(rst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .sens_hi(sens_hi));
  dio_field u_field (.sensor(sensor), .line_out(line_out),
    .line_oe(line_oe), .line_in(line_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ------------------------------------------
  // bus and check helpers
  // ------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      results;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // waitrequest is looked at mid-cycle so the edge decision is race-free
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic w;
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do begin
      @(negedge mclk);
      w = waitrequest;
      @(posedge mclk);
    end while (w !== 1'b0);
    write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdw(input logic [7:0] a);
    logic w;
    address <= a;
    read <= 1'b1;
    do begin
      @(negedge mclk);
      w = waitrequest;
      rd = readdata;
      @(posedge mclk);
    end while (w !== 1'b0);
    read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rdw(a);
    check(rd, exp);
  endtask

  // sample ticks fall every 5000 cycles after the run write
  task automatic to_tick(input int k);
    while (cyc < run_cyc + k * 5000 + 50)
      @(posedge mclk);
  endtask

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_reset;
    rdchk(dio_pkg::OFS_RATE, 32'h000f4240);
    rdchk(dio_pkg::OFS_THR + 8'h0c, 32'h00000001);
    rdchk(dio_pkg::OFS_ALM + 8'h14, 32'h00000001);
    rdchk(dio_pkg::OFS_ETHR + 8'h08, 32'h00000101);
    rdchk(dio_pkg::OFS_CTRL, 32'h00000000);
    wr(8'h30, 32'hffffffff);
    rdchk(8'h30, 32'h00000000);
    check(32'(line_oe), 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_out;
    sensor <= 8'hff;
    wr(dio_pkg::OFS_OUT, 32'h000000ff);
    repeat (3) @(posedge mclk);
    check(32'(line_oe), 32'h0000007e);
    rdw(dio_pkg::OFS_LEVELS);
    check(rd & 32'h000000ff, 32'h00000081);
    wr(dio_pkg::OFS_OUT, 32'h00000002);
    repeat (3) @(posedge mclk);
    check(32'(line_oe), 32'h00000002);
    wr(dio_pkg::OFS_SENS, 32'h00000003);
    repeat (3) @(posedge mclk);
    check(32'(sens_hi), 32'h00000003);
    wr(dio_pkg::OFS_SENS, 32'h00000002);
    wr(dio_pkg::OFS_OUT, 32'h00000000);
    sensor <= 8'h00;
    repeat (3) @(posedge mclk);
    check(32'(sens_hi), 32'h00000002);
    // rate below the fastest legal pace is pulled up to it
    wr(dio_pkg::OFS_RATE, 32'h00000001);
    rdchk(dio_pkg::OFS_RATE, 32'h00001388);
    $display("test outputs done");
  endtask

  task automatic t_count;
    logic [31:0] ts;
    wr(dio_pkg::OFS_THR, 32'h00000003);
    wr(dio_pkg::OFS_ALM, 32'h00000002);
    wr(dio_pkg::OFS_ALM + 8'h08, 32'h00000002);
    wr(dio_pkg::OFS_FILT_EN, 32'h00000001);
    wr(dio_pkg::OFS_INVERT, 32'h00000002);
    wr(dio_pkg::OFS_BOTH, 32'h00000004);
    wr(dio_pkg::OFS_CTRL, 32'h00000003);
    run_cyc = cyc;
    sensor <= 8'h07;
    to_tick(2);
    rdw(dio_pkg::OFS_LEVELS);
    check(rd & 32'h00000100, 32'h00000000);
    rdchk(dio_pkg::OFS_CNT, 32'h00000000);
    rdchk(dio_pkg::OFS_CNT + 8'h04, 32'h00000000);
    rdchk(dio_pkg::OFS_CNT + 8'h08, 32'h00000001);
    to_tick(3);
    rdw(dio_pkg::OFS_LEVELS);
    check(rd & 32'h00000100, 32'h00000100);
    rdchk(dio_pkg::OFS_CNT, 32'h00000001);
    to_tick(4);
    sensor <= 8'h00;
    to_tick(6);
    rdw(dio_pkg::OFS_LEVELS);
    check(rd & 32'h00000100, 32'h00000100);
    to_tick(7);
    rdw(dio_pkg::OFS_LEVELS);
    check(rd & 32'h00000100, 32'h00000000);
    rdchk(dio_pkg::OFS_CNT, 32'h00000001);
    rdchk(dio_pkg::OFS_CNT + 8'h04, 32'h00000001);
    rdchk(dio_pkg::OFS_CNT + 8'h08, 32'h00000002);
    rdw(dio_pkg::OFS_STATUS);
    check(rd & 32'h000100ff, 32'h00010006);
    rdw(dio_pkg::OFS_TS);
    ts = rd;
    rdw(dio_pkg::OFS_TIME);
    check(32'(ts != 32'h0 && ts <= rd), 32'h00000001);
    $display("test counters done");
  endtask

  task automatic t_enc;
    wr(dio_pkg::OFS_STATUS, 32'hffffffff);
    rdchk(dio_pkg::OFS_STATUS, 32'h00000000);
    wr(dio_pkg::OFS_ETHR, 32'h00000202);
    wr(dio_pkg::OFS_ENC_EN, 32'h00000001);
    to_tick(8);
    sensor <= 8'h01;
    to_tick(9);
    sensor <= 8'h03;
    to_tick(10);
    rdw(dio_pkg::OFS_ECNT);
    check(rd, 32'h00000002);
    rdw(dio_pkg::OFS_STATUS);
    check(rd & 32'h0000ff00, 32'h00000100);
    check(rd & 32'h000000ff, 32'h00000000);
    sensor <= 8'h01;
    to_tick(11);
    sensor <= 8'h00;
    to_tick(12);
    rdchk(dio_pkg::OFS_ECNT, 32'h00000000);
    rdchk(dio_pkg::OFS_CNT, 32'h00000001);
    $display("test encoder done");
  endtask

  task automatic t_pulse;
    wr(dio_pkg::OFS_PULSE, 32'h00020001);
    repeat (3) @(posedge mclk);
    check(32'(line_oe), 32'h00000002);
    rdchk(dio_pkg::OFS_PULSE, 32'h00000002);
    repeat (40) @(posedge mclk);
    check(32'(line_oe), 32'h00000000);
    for (int i = 0; i < 8; i += 7) begin
      wr(dio_pkg::OFS_PULSE, 32'h00020000 | 32'(i));
      repeat (3) @(posedge mclk);
      check(32'(line_oe), 32'h00000000);
    end
    wr(dio_pkg::OFS_OUT, 32'h00000004);
    wr(dio_pkg::OFS_PULSE, 32'h00020002);
    repeat (3) @(posedge mclk);
    check(32'(line_oe), 32'h00000000);
    repeat (40) @(posedge mclk);
    check(32'(line_oe), 32'h00000004);
    wr(dio_pkg::OFS_CTRL, 32'h00000000);
    wr(dio_pkg::OFS_PULSE, 32'h00020002);
    repeat (3) @(posedge mclk);
    check(32'(line_oe), 32'h00000004);
    rdchk(dio_pkg::OFS_PULSE, 32'h00000000);
    $display("test pulse done");
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    byteenable = 4'hf;
    sensor = 8'h00;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_out;
    t_count;
    t_enc;
    t_pulse;
    results;
  end
endmodule
